/* File: rtl/esr_top.v */
// Embedded synchronous RAM block with an AXI4-Lite configuration slave.
`include "esr_defines.vh"

module esr_top #(
  parameter [1:0] BLOCK_KIND = `ESR_KIND_MEDIUM
) (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  reset,
  // AXI4-Lite write address and data.
  input  wire [7:0]            s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // AXI4-Lite write response.
  output wire [1:0]            s_axi_bresp,
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read.
  input  wire [7:0]            s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output wire [31:0]           s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Memory port A.
  input  wire                  a_we,
  input  wire [`ESR_LANES-1:0] a_be,
  input  wire [`ESR_AW_MAX-1:0] a_addr,
  input  wire [`ESR_DW-1:0]    a_wdata,
  output wire [`ESR_DW-1:0]    a_rdata,
  // Memory port B; the extra address bit picks a half in narrow mode.
  input  wire                  b_we,
  input  wire [`ESR_LANES-1:0] b_be,
  input  wire [`ESR_AW_MAX:0]  b_addr,
  input  wire [`ESR_DW-1:0]    b_wdata,
  output wire [`ESR_DW-1:0]    b_rdata
);

  localparam AW = (BLOCK_KIND == `ESR_KIND_SMALL)  ? `ESR_AW_SMALL  :
                  (BLOCK_KIND == `ESR_KIND_MEDIUM) ? `ESR_AW_MEDIUM :
                  `ESR_AW_LARGE;
  localparam [23:0] BITS =
                  (BLOCK_KIND == `ESR_KIND_SMALL)  ? `ESR_BITS_SMALL  :
                  (BLOCK_KIND == `ESR_KIND_MEDIUM) ? `ESR_BITS_MEDIUM :
                  `ESR_BITS_LARGE;
  localparam [3:0] AW4      = AW;
  localparam       IS_SMALL = (BLOCK_KIND == `ESR_KIND_SMALL);
  localparam       IS_MED   = (BLOCK_KIND == `ESR_KIND_MEDIUM);
  localparam       IS_LARGE = (BLOCK_KIND == `ESR_KIND_LARGE);

  localparam [2:0] SEL_CTRL   = 3'h0;
  localparam [2:0] SEL_STATUS = 3'h1;
  localparam [2:0] SEL_INFO   = 3'h2;
  localparam [2:0] SEL_TAP    = 3'h3;
  localparam [2:0] SEL_NONE   = 3'h7;

  // Bus slave state.
  reg                     awready_q;
  reg                     wready_q;
  reg                     bvalid_q;
  reg  [1:0]              bresp_q;
  reg                     arready_q;
  reg                     rvalid_q;
  reg  [31:0]             rdata_q;
  reg  [1:0]              rresp_q;
  reg  [7:0]              aw_addr_q;
  reg  [31:0]             w_data_q;
  reg  [3:0]              w_strb_q;

  // Configuration and status.
  reg  [`ESR_CTRL_W-1:0]  ctrl_q;
  reg  [1:0]              status_q;
  reg  [1:0]              status_d;
  reg  [`ESR_AW_MAX-1:0]  tap_q;

  // Memory side.
  reg  [AW-1:0]           ptr_q;
  reg                     half_q;
  reg  [`ESR_DW-1:0]      a_out_q;
  reg  [`ESR_DW-1:0]      b_out_q;
  reg  [31:0]             rd_word;
  reg  [1:0]              rd_resp;

  wire [`ESR_DW-1:0]      rd_a;
  wire [`ESR_DW-1:0]      rd_b;

  // Maps a byte address to a register select; used by both directions.
  function [2:0] reg_sel;
    input [7:0] ad;
    begin
      if (ad == `ESR_OFF_CTRL)
        reg_sel = SEL_CTRL;
      else if (ad == `ESR_OFF_STATUS)
        reg_sel = SEL_STATUS;
      else if (ad == `ESR_OFF_INFO)
        reg_sel = SEL_INFO;
      else if (ad == `ESR_OFF_TAP)
        reg_sel = SEL_TAP;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // Features that a variant lacks are forced off whatever software writes.
  wire old_ok    = ctrl_q[`ESR_CTRL_OLD] && !IS_LARGE;
  wire oreg_a    = ctrl_q[`ESR_CTRL_OREG_A];
  wire oreg_b    = ctrl_q[`ESR_CTRL_OREG_B];
  wire narrow    = ctrl_q[`ESR_CTRL_NARROW];
  wire packed_on = ctrl_q[`ESR_CTRL_PACKED] && IS_MED;
  wire shift_on  = ctrl_q[`ESR_CTRL_SHIFT] && !IS_LARGE;

  wire do_write  = !awready_q && !wready_q && !bvalid_q;
  wire [2:0] wsel = reg_sel(aw_addr_q);

  // Port A address: plain, lower half when packed, or the shift pointer.
  wire [AW-1:0] plain_a = packed_on ? {1'b0, a_addr[AW-2:0]}
                                    : a_addr[AW-1:0];
  wire [AW-1:0] ea_a    = shift_on ? ptr_q : plain_a;
  wire [`ESR_LANES-1:0] be_a = IS_SMALL ? {`ESR_LANES{1'b1}} : a_be;

  // Port B address: word or half-word view, upper half when packed.
  wire [AW-1:0] word_b  = narrow ? b_addr[AW:1] : b_addr[AW-1:0];
  wire [AW-1:0] plain_b = packed_on ? {1'b1, word_b[AW-2:0]} : word_b;
  wire [AW-1:0] tap_b   = ptr_q - tap_q[AW-1:0];
  wire [AW-1:0] ea_b    = shift_on ? tap_b : plain_b;
  wire          we_b    = b_we && !shift_on;

  wire [`ESR_LANES-1:0] nbe_b = b_addr[0] ? {b_be[1:0], 2'h0}
                                          : {2'h0, b_be[1:0]};
  wire [`ESR_LANES-1:0] wbe_b = narrow ? nbe_b : b_be;
  wire [`ESR_LANES-1:0] be_b  = IS_SMALL ? {`ESR_LANES{1'b1}} : wbe_b;
  wire [`ESR_DW-1:0]    wd_b  = narrow ? {b_wdata[`ESR_HALF-1:0],
                                          b_wdata[`ESR_HALF-1:0]}
                                       : b_wdata;

  // Collisions seen on the edge that the array takes the inputs.
  wire hit_ab = a_we && !we_b && (ea_a == ea_b);
  wire hit_ba = we_b && !a_we && (ea_a == ea_b);

  esr_mem #(
    .AW     (AW)
  ) u_mem (
    .clk    (clk),
    .reset  (reset),
    .we_a   (a_we),
    .be_a   (be_a),
    .addr_a (ea_a),
    .wd_a   (a_wdata),
    .rd_a   (rd_a),
    .we_b   (we_b),
    .be_b   (be_b),
    .addr_b (ea_b),
    .wd_b   (wd_b),
    .rd_b   (rd_b),
    .old_ok (old_ok)
  );

  // Narrow view of port B returns the half picked when the read was taken.
  wire [`ESR_HALF-1:0] b_half = half_q ? rd_b[`ESR_DW-1:`ESR_HALF]
                                       : rd_b[`ESR_HALF-1:0];
  wire [`ESR_DW-1:0]   b_view = narrow ? {{`ESR_HALF{1'b0}}, b_half}
                                       : rd_b;

  // Optional output stage, one cycle behind the array read.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      a_out_q <= {`ESR_DW{1'b0}};
      b_out_q <= {`ESR_DW{1'b0}};
      half_q  <= 1'b0;
    end
    else
    begin
      a_out_q <= rd_a;
      b_out_q <= b_view;
      half_q  <= b_addr[0];
    end
  end

  assign a_rdata = oreg_a ? a_out_q : rd_a;
  assign b_rdata = oreg_b ? b_out_q : b_view;

  // Shift pointer advances on every port A write in shift mode.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      ptr_q <= {AW{1'b0}};
    else if (shift_on && a_we)
      ptr_q <= ptr_q + 1'b1;
  end

  // Sticky collision flags; a new event outweighs a clear in one cycle.
  always @*
  begin
    status_d = status_q;
    if (do_write && (wsel == SEL_STATUS) && w_strb_q[0])
      status_d = status_q & ~w_data_q[1:0];
    if (hit_ab)
      status_d[`ESR_ST_HIT_AB] = 1'b1;
    if (hit_ba)
      status_d[`ESR_ST_HIT_BA] = 1'b1;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
      status_q <= `ESR_ST_RST;
    else
      status_q <= status_d;
  end

  // Write address and data are taken independently, in either order.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ESR_RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wsel == SEL_NONE) ? `ESR_RESP_SLVERR : `ESR_RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Register updates from a completed bus write.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= `ESR_CTRL_RST;
      tap_q  <= `ESR_TAP_RST;
    end
    else if (do_write)
    begin
      if ((wsel == SEL_CTRL) && w_strb_q[0])
        ctrl_q <= w_data_q[`ESR_CTRL_W-1:0];
      if ((wsel == SEL_TAP) && w_strb_q[0])
        tap_q[7:0] <= w_data_q[7:0];
      if ((wsel == SEL_TAP) && w_strb_q[1])
        tap_q[`ESR_AW_MAX-1:8] <= w_data_q[`ESR_AW_MAX-1:8];
    end
  end

  // Read data selection.
  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_resp = `ESR_RESP_OKAY;
    case (reg_sel(s_axi_araddr))
      SEL_CTRL:
        rd_word = {26'h000_0000, ctrl_q};
      SEL_STATUS:
        rd_word = {30'h0000_0000, status_q};
      SEL_INFO:
        rd_word = {BITS, AW4, 2'h0, BLOCK_KIND};
      SEL_TAP:
        rd_word = {18'h0_0000, tap_q};
      default:
        rd_resp = `ESR_RESP_SLVERR;
    endcase
  end

  // One read at a time; the answer follows the address by one edge.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ESR_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_resp;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // esr_top

/* File: inc/esr_defines.vh */
// Constants for the embedded synchronous RAM block and its register file.
// Summary of operation
// - Small variant stores 576 bits including parity.
// - Medium variant stores 4,608 bits including parity.
// - Large variant stores 589,824 bits including parity.
// - Byte masks (not small), parity storage, shift mode (not large), mixed widths, true dual port.
// - Medium block packs two single-port memories into one dual-port block.
// - Address and write data are registered on the edge before use.
// - Read data either passes an output register or comes straight out.
// - A port may read and write one address on the same clock.
// - Same-port read during write returns the new data at once.
// - Mixed-port collision: one port reads what the other writes.
// - Reading port sees the new data from the following cycle on.
// - Small and medium select old data or don't care on collision.
// - Large block always returns don't care on collision.
`ifndef ESR_DEFINES_VH
`define ESR_DEFINES_VH

// Block variants.
`define ESR_KIND_SMALL   2'h0
`define ESR_KIND_MEDIUM  2'h1
`define ESR_KIND_LARGE   2'h2

// Word layout: four lanes of eight data bits and one parity bit.
`define ESR_DW           36
`define ESR_LANE         9
`define ESR_LANES        4
`define ESR_HALF         18

// Word address widths per variant.
`define ESR_AW_SMALL     4
`define ESR_AW_MEDIUM    7
`define ESR_AW_LARGE     14
`define ESR_AW_MAX       14

// Total storage bits per variant.
`define ESR_BITS_SMALL   24'h00_0240
`define ESR_BITS_MEDIUM  24'h00_1200
`define ESR_BITS_LARGE   24'h09_0000

// Register byte offsets.
`define ESR_OFF_CTRL     8'h00
`define ESR_OFF_STATUS   8'h04
`define ESR_OFF_INFO     8'h08
`define ESR_OFF_TAP      8'h0C

// Control register fields.
`define ESR_CTRL_OLD     0
`define ESR_CTRL_OREG_A  1
`define ESR_CTRL_OREG_B  2
`define ESR_CTRL_NARROW  3
`define ESR_CTRL_PACKED  4
`define ESR_CTRL_SHIFT   5
`define ESR_CTRL_W       6
`define ESR_CTRL_RST     6'h00

// Status register fields.
`define ESR_ST_HIT_AB    0
`define ESR_ST_HIT_BA    1
`define ESR_ST_RST       2'h0

// Shift tap distance reset value.
`define ESR_TAP_RST      14'h0000

// Value returned for an undefined read.
`define ESR_DONT_CARE    36'hF_FFFF_FFFF

// Bus responses.
`define ESR_RESP_OKAY    2'h0
`define ESR_RESP_SLVERR  2'h2

`endif

/* File: rtl/esr_mem.v */
// Storage array of the RAM block with registered inputs and read registers.
`include "esr_defines.vh"

module esr_mem #(
  parameter AW = 7
) (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  reset,
  // Port A.
  input  wire                  we_a,
  input  wire [`ESR_LANES-1:0] be_a,
  input  wire [AW-1:0]         addr_a,
  input  wire [`ESR_DW-1:0]    wd_a,
  output wire [`ESR_DW-1:0]    rd_a,
  // Port B.
  input  wire                  we_b,
  input  wire [`ESR_LANES-1:0] be_b,
  input  wire [AW-1:0]         addr_b,
  input  wire [`ESR_DW-1:0]    wd_b,
  output wire [`ESR_DW-1:0]    rd_b,
  // Collision behaviour: high returns old data.
  input  wire                  old_ok
);

  reg [`ESR_DW-1:0] mem_q [0:(1<<AW)-1];
  reg [`ESR_DW-1:0] rd_a_q;
  reg [`ESR_DW-1:0] rd_b_q;

  // Replaces the masked lanes of a stored word with new data.
  function [`ESR_DW-1:0] merge;
    input [`ESR_DW-1:0]    old_w;
    input [`ESR_DW-1:0]    new_w;
    input [`ESR_LANES-1:0] be;
    integer i;
    begin
      merge = old_w;
      for (i = 0; i < `ESR_LANES; i = i + 1)
        if (be[i])
          merge[i*`ESR_LANE +: `ESR_LANE] = new_w[i*`ESR_LANE +: `ESR_LANE];
    end
  endfunction

  wire [`ESR_DW-1:0] new_a  = merge(mem_q[addr_a], wd_a, be_a);
  wire [`ESR_DW-1:0] new_b  = merge(mem_q[addr_b], wd_b, be_b);
  wire               hit_ab = we_a && (addr_a == addr_b);
  wire               hit_ba = we_b && (addr_a == addr_b);

  // Strobe, mask, data and address are taken on one edge and used there.
  always @(posedge clk)
  begin
    if (we_b)
      mem_q[addr_b] <= new_b;
    if (we_a)
      mem_q[addr_a] <= new_a;
  end

  // A writing port sees its own new word; the other port sees old data or
  // the don't-care pattern, and the stored word from the next cycle on.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_a_q <= {`ESR_DW{1'b0}};
      rd_b_q <= {`ESR_DW{1'b0}};
    end
    else
    begin
      if (we_a)
        rd_a_q <= new_a;
      else if (hit_ba && !old_ok)
        rd_a_q <= `ESR_DONT_CARE;
      else
        rd_a_q <= mem_q[addr_a];
      if (we_b)
        rd_b_q <= new_b;
      else if (hit_ab && !old_ok)
        rd_b_q <= `ESR_DONT_CARE;
      else
        rd_b_q <= mem_q[addr_b];
    end
  end

  assign rd_a = rd_a_q;
  assign rd_b = rd_b_q;

endmodule // esr_mem

/* File: tb/esr_top_properties.sv */
// Concurrent checks on the ports of the RAM block top module.
`include "esr_defines.vh"

module esr_props #(
  parameter [1:0] BLOCK_KIND = `ESR_KIND_MEDIUM
) (
  // Clock and reset.
  input logic                   clk,
  input logic                   reset,
  // Configuration writes.
  input logic [7:0]             s_axi_awaddr,
  input logic                   s_axi_awvalid,
  input logic                   s_axi_awready,
  input logic [31:0]            s_axi_wdata,
  input logic [3:0]             s_axi_wstrb,
  input logic                   s_axi_wvalid,
  input logic                   s_axi_wready,
  input logic                   s_axi_bvalid,
  input logic                   s_axi_bready,
  // Memory ports.
  input logic                   a_we,
  input logic [`ESR_LANES-1:0]  a_be,
  input logic [`ESR_AW_MAX-1:0] a_addr,
  input logic [`ESR_DW-1:0]     a_wdata,
  input logic [`ESR_DW-1:0]     a_rdata,
  input logic                   b_we,
  input logic [`ESR_LANES-1:0]  b_be,
  input logic [`ESR_AW_MAX:0]   b_addr,
  input logic [`ESR_DW-1:0]     b_wdata,
  input logic [`ESR_DW-1:0]     b_rdata
);
  localparam int AW = (BLOCK_KIND == 0) ? 4 : (BLOCK_KIND == 1) ? 7 : 14;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic        ws_q;
  logic [5:0]  ctrl_q;
  logic        hit;
  logic [8:0]  lane1;
  // Control bits are mirrored from completed bus writes.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aw_q   <= 8'h00;
      wd_q   <= 32'h0000_0000;
      ws_q   <= 1'b0;
      ctrl_q <= 6'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready && aw_q == 8'h00 && ws_q)
        ctrl_q <= wd_q[5:0];
    end
  end
  assign lane1 = a_wdata[17:9];
  assign hit = a_we && !b_we && a_be == 4'hF && !ctrl_q[2] && !ctrl_q[3]
    && !ctrl_q[4] && !ctrl_q[5] && a_addr[AW-1:0] == b_addr[AW-1:0];

  property p_same_a;
    @(posedge clk) disable iff (reset)
    a_we && a_be == 4'hF && !ctrl_q[1] && !ctrl_q[5]
    |=> a_rdata == $past(a_wdata);
  endproperty
  a_same_a: assert property (p_same_a)
    else $error("port A read during write mismatch");
  property p_same_b;
    @(posedge clk) disable iff (reset)
    b_we && b_be == 4'hF && !ctrl_q[2] && !ctrl_q[3] && !ctrl_q[5]
    |=> b_rdata == $past(b_wdata);
  endproperty
  a_same_b: assert property (p_same_b)
    else $error("port B read during write mismatch");
  property p_mask;
    @(posedge clk) disable iff (reset)
    a_we && a_be == 4'h2 && BLOCK_KIND != 0 && !ctrl_q[1] && !ctrl_q[5]
    |=> a_rdata[17:9] == $past(lane1);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked lane not written");
  property p_oreg;
    @(posedge clk) disable iff (reset)
    a_we && a_be == 4'hF && ctrl_q[1] && !ctrl_q[5]
    |=> ##1 a_rdata == $past(a_wdata, 2);
  endproperty
  a_oreg: assert property (p_oreg)
    else $error("registered output late or wrong");
  property p_mix_new;
    @(posedge clk) disable iff (reset)
    hit ##1 (!a_we && !b_we && $stable(b_addr))
    |=> b_rdata == $past(a_wdata, 2);
  endproperty
  a_mix_new: assert property (p_mix_new)
    else $error("new data not seen on the other port");
  property p_mix_old;
    @(posedge clk) disable iff (reset)
    hit && ctrl_q[0] && BLOCK_KIND != 2 && $stable(b_addr) && !$past(a_we)
      && !$past(b_we) && !$past(reset)
    |=> b_rdata == $past(b_rdata);
  endproperty
  a_mix_old: assert property (p_mix_old)
    else $error("old data not kept on collision");
  property p_mix_dc;
    @(posedge clk) disable iff (reset)
    hit && (!ctrl_q[0] || BLOCK_KIND == 2) |=> b_rdata == `ESR_DONT_CARE;
  endproperty
  a_mix_dc: assert property (p_mix_dc)
    else $error("collision value not the undefined pattern");
  property p_rst;
    @(posedge clk) reset |-> a_rdata == '0 && b_rdata == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared in reset");
  c_hit: cover property (@(posedge clk) disable iff (reset) hit);
  c_oreg: cover property (@(posedge clk) disable iff (reset) a_we && ctrl_q[1]);
  c_same_b: cover property (@(posedge clk) disable iff (reset) b_we);
endmodule // esr_props

bind esr_top esr_props #(.BLOCK_KIND(BLOCK_KIND)) u_props (.clk, .reset,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .a_we, .a_be,
  .a_addr, .a_wdata, .a_rdata, .b_we, .b_be, .b_addr, .b_wdata, .b_rdata);

/* File: tb/esr_user.sv */
// User logic model that drives both memory ports from the block clock.
`include "esr_defines.vh"

module esr_user (
  // Clock.
  input  logic                   clk,
  // Port A.
  output logic                   a_we,
  output logic [`ESR_LANES-1:0]  a_be,
  output logic [`ESR_AW_MAX-1:0] a_addr,
  output logic [`ESR_DW-1:0]     a_wdata,
  // Port B.
  output logic                   b_we,
  output logic [`ESR_LANES-1:0]  b_be,
  output logic [`ESR_AW_MAX:0]   b_addr,
  output logic [`ESR_DW-1:0]     b_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    a_we = 1'b0;
    a_be = 4'hF;
    a_addr = '0;
    a_wdata = '0;
    b_we = 1'b0;
    b_be = 4'hF;
    b_addr = '0;
    b_wdata = '0;
  end
  // One cycle of both ports; idle write data toggles so it never looks held.
  task step(input logic aw, input logic [3:0] ab, input logic [13:0] aa,
            input logic [35:0] ad, input logic bw, input logic [14:0] ba,
            input logic [35:0] bd);
    @(posedge clk);
    a_we <= aw;
    a_be <= ab;
    a_addr <= aa;
    a_wdata <= aw ? ad : ~a_wdata;
    b_we <= bw;
    b_addr <= ba;
    b_wdata <= bw ? bd : ~b_wdata;
  endtask
endmodule // esr_user

/* File: tb/esr_top_tb.sv */
// Self-checking bench for the RAM block top module.
`include "esr_defines.vh"

module esr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [35:0] D1 = 36'h1_2345_6789;
  localparam logic [35:0] D2 = 36'h9_8765_4321;
  localparam logic [35:0] D3 = 36'hA_BCDE_F012;
  localparam logic [35:0] V1 = 36'h0_1111_2222;
  localparam logic [35:0] V2 = 36'h3_3333_4444;
  localparam logic [35:0] D4 = 36'h5_5555_6666;
  logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        a_we, b_we;
  logic [3:0]  a_be, b_be;
  logic [13:0] a_addr;
  logic [14:0] b_addr;
  logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata;
  int          fails, cmp_count, cyc;

  esr_top #(.BLOCK_KIND(`ESR_KIND_MEDIUM)) dut_u (.clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_we(a_we), .a_be(a_be),
    .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata), .b_we(b_we),
    .b_be(b_be), .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata));
  esr_user u_user (.clk(clk), .a_we(a_we), .a_be(a_be), .a_addr(a_addr),
    .a_wdata(a_wdata), .b_we(b_we), .b_be(b_be), .b_addr(b_addr),
    .b_wdata(b_wdata));

  task give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [35:0] g, input logic [35:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task axi_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({34'h0, bresp}, {34'h0, `ESR_RESP_OKAY}, "write response");
  endtask
  task axi_rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({4'h0, rdata}, {4'h0, e}, "read data");
    chk({34'h0, rresp}, {34'h0, r}, "read response");
  endtask
  task t_reset;
    chk(a_rdata, '0, "A after reset");
    chk(b_rdata, '0, "B after reset");
    axi_rd(`ESR_OFF_INFO, {`ESR_BITS_MEDIUM, 4'h7, 2'h0, `ESR_KIND_MEDIUM},
           `ESR_RESP_OKAY);
    axi_rd(8'h10, 32'h0000_0000, `ESR_RESP_SLVERR);
  endtask
  task t_same;
    u_user.step(1'b1, 4'hF, 14'h5, D1, 1'b1, 15'h9, D2);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'h9, D2);
    #1 chk(a_rdata, D1, "A write-first");
    chk(b_rdata, D2, "B write-first");
    u_user.step(1'b1, 4'h2, 14'h5, D3, 1'b0, 15'h9, D2);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'h9, D2);
    #1 chk(a_rdata, {D1[35:18], D3[17:9], D1[8:0]}, "lane mask");
  endtask
  task t_mixed(input logic old);
    axi_wr(`ESR_OFF_CTRL, {31'h0, old});
    u_user.step(1'b1, 4'hF, 14'h3, V1, 1'b0, 15'h3, D2);
    u_user.step(1'b0, 4'hF, 14'h3, V1, 1'b0, 15'h3, D2);
    u_user.step(1'b1, 4'hF, 14'h3, V2, 1'b0, 15'h3, D2);
    u_user.step(1'b0, 4'hF, 14'h3, V2, 1'b0, 15'h3, D2);
    #1 chk(b_rdata, old ? V1 : `ESR_DONT_CARE, "collision cycle");
    u_user.step(1'b0, 4'hF, 14'h3, V2, 1'b0, 15'h3, D2);
    #1 chk(b_rdata, V2, "cycle after collision");
    axi_rd(`ESR_OFF_STATUS, 32'h0000_0001, `ESR_RESP_OKAY);
    axi_wr(`ESR_OFF_STATUS, 32'h0000_0003);
    axi_rd(`ESR_OFF_STATUS, 32'h0000_0000, `ESR_RESP_OKAY);
  endtask
  // Packed halves stay apart; narrow port B writes one half of a word.
  task t_modes;
    axi_wr(`ESR_OFF_CTRL, 32'h0000_0010);
    u_user.step(1'b1, 4'hF, 14'h5, D1, 1'b1, 15'h5, D2);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'h5, D2);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'h5, D2);
    #1 chk(a_rdata, D1, "packed lower half");
    chk(b_rdata, D2, "packed upper half");
    axi_wr(`ESR_OFF_CTRL, 32'h0000_0008);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b1, 15'hB, V1);
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'hB, V1);
    #1 chk(a_rdata, `ESR_DONT_CARE, "mixed width collision");
    chk(b_rdata, {18'h0_0000, V1[17:0]}, "narrow write-first");
    u_user.step(1'b0, 4'hF, 14'h5, D1, 1'b0, 15'hB, V1);
    #1 chk(a_rdata, {V1[17:0], D1[17:0]}, "narrow upper half");
    axi_rd(`ESR_OFF_STATUS, 32'h0000_0002, `ESR_RESP_OKAY);
  endtask
  task t_oreg;
    axi_wr(`ESR_OFF_CTRL, 32'h0000_0002);
    u_user.step(1'b0, 4'hF, 14'h3, D4, 1'b0, 15'h9, D2);
    u_user.step(1'b1, 4'hF, 14'h7, D4, 1'b0, 15'h9, D2);
    u_user.step(1'b0, 4'hF, 14'h7, D4, 1'b0, 15'h9, D2);
    #1 chk(a_rdata, V2, "output register holds prior word");
    u_user.step(1'b0, 4'hF, 14'h7, D4, 1'b0, 15'h9, D2);
    #1 chk(a_rdata, D4, "output register one edge later");
    u_user.step(1'b0, 4'hF, 14'h7, D4, 1'b0, 15'h9, D2);
    #1 chk(a_rdata, D4, "output register keeps word");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict;
    end
  end
  initial
  begin
    {fails, cmp_count, cyc} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1 t_reset;
    t_same;
    t_mixed(1'b1);
    t_mixed(1'b0);
    t_modes;
    t_oreg;
    give_verdict;
  end
endmodule // esr_top_tb
